// File: rtl/irq_src_pkg.sv
// package: register map, field layout and reset values of the internal source control block
package irq_src_pkg;
   // word indices as printed (all multiples of two); the byte address is four times the index
   localparam logic [7:0] IDX_REQUEST = 8'h2e;
   localparam logic [7:0] IDX_TIMER_STS = 8'h30;
   localparam logic [7:0] IDX_TIMER_CTL = 8'h32;
   localparam logic [7:0] IDX_DMA0_CTL = 8'h34;
   localparam logic [7:0] IDX_DMA1_CTL = 8'h36;
   localparam logic [7:0] IDX_WDOG_CTL = 8'h42;
   localparam logic [7:0] IDX_SERIAL_CTL = 8'h44;
   // own registers: shared mask view and priority threshold
   localparam logic [7:0] IDX_GLOBAL_MASK = 8'h28;
   localparam logic [7:0] IDX_PRIO_THRESH = 8'h2a;
   localparam int ADDR_W = 10;
   // control register fields
   localparam int MASK_BIT = 3;
   localparam int PRIO_LSB = 0;
   localparam int PRIO_W = 3;
   localparam int SER_FIXED_BIT = 4;
   // request register bit positions, status halt bit and source counts
   localparam int REQ_TMR = 0;
   localparam int REQ_DMA0 = 2;
   localparam int REQ_DMA1 = 3;
   localparam int REQ_EXT_LSB = 4;
   localparam int REQ_WDOG = 9;
   localparam int REQ_SERIAL = 10;
   localparam int STS_HALT = 15;
   localparam int NUM_EXT = 5;
   localparam int NUM_TMR = 3;
   // reset values
   localparam logic [15:0] CTL_RESET = 16'h000f;
   localparam logic [15:0] SER_CTL_RESET = 16'h001f;
   localparam logic [2:0] THRESH_RESET = 3'h7;
   // vector types
   localparam logic [7:0] VEC_TMR0 = 8'h08;
   localparam logic [7:0] VEC_TMR1 = 8'h12;
   localparam logic [7:0] VEC_TMR2 = 8'h13;
   localparam logic [7:0] VEC_DMA0 = 8'h0a;
   localparam logic [7:0] VEC_DMA1 = 8'h0b;
   localparam logic [7:0] VEC_WDOG = 8'h11;
   localparam logic [7:0] VEC_SERIAL = 8'h14;
   // internal sources in one order: timer, dma0, dma1, watchdog, serial
   localparam int NUM_SRC = 5;
   localparam int SRC_TMR = 0;
   localparam int SRC_DMA0 = 1;
   localparam int SRC_DMA1 = 2;
   localparam int SRC_WDOG = 3;
   localparam int SRC_SERIAL = 4;

   typedef struct packed {
      logic transmit_holding_empty;
      logic receive_data_ready;
      logic break_detected;
      logic framing_error_flag;
      logic parity_error_flag;
      logic overrun_error_flag;
   } serial_flags_t;

   typedef struct packed {
      logic [NUM_SRC-1:0] source_mask_bit;
      logic [NUM_SRC-1:0][PRIO_W-1:0] source_priority_field;
   } src_ctl_t;
endpackage : irq_src_pkg

// File: rtl/internal_irq_source_control.sv
// internal interrupt source control: control, status and request registers on apb
//
// Notes on behaviour
// RQ1: timer, dma0 and dma1 control registers reset to 000Fh, upper bits zero.
// RQ2: control bit 3 masks the source when one.
// RQ3: each mask bit is one storage bit shared with the global mask view.
// RQ4: control bits 2..0 hold the source priority.
// RQ5: priority zero is highest, seven lowest.
// RQ6: unmasked source with priority above threshold is blocked.
// RQ7: timers use vectors 08h, 12h, 13h under one control register.
// RQ8: dma0 uses vector 0Ah, dma1 uses 0Bh.
// RQ9: watchdog source is timer 1 output, vector 11h.
// RQ10: watchdog control resets to 000Fh, mask bit 3, priority 2..0.
// RQ11: software writes zero to watchdog control bit 4.
// RQ12: software sets up the watchdog timer before its control register.
// RQ13: serial source uses vector 14h, request at bit 10.
// RQ14: serial control resets to 001Fh, bit 4 held at one.
// RQ15: status bit 15 suspends dma while one; software may write it.
// RQ16: halt bit sets on nonmaskable interrupt, clears on interrupt return.
// RQ17: software leaves halt bit alone while timer interrupts enabled.
// RQ18: status bits 2..0 show pending per-timer requests.
// RQ19: request bit 0 is the or of the three timer bits.
// RQ20: each internal source sets its request bit when it requests.
// RQ21: watchdog and dma request bits clear at their internal acknowledge.
// RQ22: serial request bit stays until its serial condition clears.
// RQ23: serial request is the or of six serial status flags; the code also ands that or with serial_irq_enable.
// RQ24: request bits 8..4 follow external pins 4..0 unlatched.
// RQ25: external devices hold request pins high until serviced.
// RQ26: request register is read-only; reserved bits read zero.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module internal_irq_source_control #(
   parameter logic [7:0] ID_TAG = 8'h5a  // arbitrary value, not used by logic
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [irq_src_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [irq_src_pkg::NUM_TMR-1:0] timer_irq,
   input wire logic timer1_output,
   input wire logic [1:0] dma_done_irq,
   input wire logic [1:0] dma_ack,
   input wire logic wdog_ack,
   input wire logic [irq_src_pkg::NUM_TMR-1:0] timer_ack,
   input wire logic serial_irq_enable,
   input wire irq_src_pkg::serial_flags_t serial_flags,
   input wire logic [irq_src_pkg::NUM_EXT-1:0] external_pin_requests,
   input wire logic nmi_taken,
   input wire logic irq_return,
   output logic dma_suspend,
   output logic [irq_src_pkg::NUM_SRC-1:0] source_eligible,
   output irq_src_pkg::src_ctl_t src_ctl
);
   logic [irq_src_pkg::NUM_EXT-1:0] ext_meta;
   logic [irq_src_pkg::NUM_EXT-1:0] ext_sync;
   logic [irq_src_pkg::NUM_SRC-1:0] source_mask_bit;
   logic [irq_src_pkg::NUM_SRC-1:0][2:0] source_priority_field;
   logic [2:0] priority_threshold;
   logic dma_suspend_flag;
   logic [irq_src_pkg::NUM_TMR-1:0] per_timer_request_bits;
   logic [1:0] dma_channel_requests;
   logic watchdog_request;
   logic serial_request;
   logic wdog_prev;
   logic wr_en;
   logic rd_en;
   logic [7:0] word_idx;
   logic addr_ok;
   logic [15:0] wdata;
   logic [15:0] request_view;
   logic [15:0] status_view;
   logic [15:0] rdata_mux;
   logic [irq_src_pkg::NUM_SRC-1:0] ctl_hit;
   logic [irq_src_pkg::NUM_SRC-1:0] pending;

   // index kept as printed; byte address is four times it
   assign word_idx = paddr[9:2];
   assign wdata = pwdata[15:0];
   // a write without both low byte strobes (pstrb[1:0]) is dropped, but the access is still answered
   // ready low gates the take, so a request held into the answer cycle is not taken twice
   assign wr_en = psel & penable & pwrite & ~pready & addr_ok & (&pstrb[1:0]);
   assign rd_en = psel & penable & ~pwrite & ~pready;

   always_comb
   begin
      ctl_hit = '0;
      ctl_hit[irq_src_pkg::SRC_TMR] = word_idx == irq_src_pkg::IDX_TIMER_CTL;
      ctl_hit[irq_src_pkg::SRC_DMA0] = word_idx == irq_src_pkg::IDX_DMA0_CTL;
      ctl_hit[irq_src_pkg::SRC_DMA1] = word_idx == irq_src_pkg::IDX_DMA1_CTL;
      ctl_hit[irq_src_pkg::SRC_WDOG] = word_idx == irq_src_pkg::IDX_WDOG_CTL;
      ctl_hit[irq_src_pkg::SRC_SERIAL] = word_idx == irq_src_pkg::IDX_SERIAL_CTL;
      // unlisted indices answer with pslverr and read zero
      addr_ok = (|ctl_hit) || word_idx == irq_src_pkg::IDX_REQUEST
         || word_idx == irq_src_pkg::IDX_TIMER_STS || word_idx == irq_src_pkg::IDX_GLOBAL_MASK
         || word_idx == irq_src_pkg::IDX_PRIO_THRESH;
   end

   // external pins come from outside the clock domain
   // two cycles of latency on the pin view; harmless for held level requests
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_meta <= '0;
         ext_sync <= '0;
      end
      else
      begin
         ext_meta <= external_pin_requests;
         ext_sync <= ext_meta;
      end
   end

   // watchdog bit 4 is not stored, so a stray one written there has no effect
   // per-source mask and priority, one generate entry per source
   for (genvar s = 0; s < irq_src_pkg::NUM_SRC; s++)
   begin : g_src
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            // RQ1 RQ10 RQ14 masked at lowest priority
            source_mask_bit[s] <= 1'b1;
            source_priority_field[s] <= irq_src_pkg::CTL_RESET[2:0];
         end
         else if (wr_en && ctl_hit[s])
         begin
            // RQ2 RQ4 mask and priority fields
            source_mask_bit[s] <= wdata[irq_src_pkg::MASK_BIT];
            source_priority_field[s] <= wdata[irq_src_pkg::PRIO_LSB +: irq_src_pkg::PRIO_W];
         end
         else if (wr_en && word_idx == irq_src_pkg::IDX_GLOBAL_MASK)
         begin
            // RQ3 same bit written via global view
            unique case (s)
               irq_src_pkg::SRC_TMR: source_mask_bit[s] <= wdata[irq_src_pkg::REQ_TMR];
               irq_src_pkg::SRC_DMA0: source_mask_bit[s] <= wdata[irq_src_pkg::REQ_DMA0];
               irq_src_pkg::SRC_DMA1: source_mask_bit[s] <= wdata[irq_src_pkg::REQ_DMA1];
               irq_src_pkg::SRC_WDOG: source_mask_bit[s] <= wdata[irq_src_pkg::REQ_WDOG];
               default: source_mask_bit[s] <= wdata[irq_src_pkg::REQ_SERIAL];
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      // threshold resets to seven so every unmasked source may request
      if (!presetn)
      begin
         priority_threshold <= irq_src_pkg::THRESH_RESET;
      end
      else if (wr_en && word_idx == irq_src_pkg::IDX_PRIO_THRESH)
      begin
         priority_threshold <= wdata[2:0];
      end
   end

   // RQ15 RQ16 halt flag; hardware events win over a software write
   always_ff @(posedge pclk or negedge presetn)
   begin
      // a software write loses to an nmi or a return in the same cycle
      if (!presetn)
      begin
         dma_suspend_flag <= 1'b0;
      end
      else if (nmi_taken)
      begin
         dma_suspend_flag <= 1'b1;
      end
      else if (irq_return)
      begin
         dma_suspend_flag <= 1'b0;
      end
      else if (wr_en && word_idx == irq_src_pkg::IDX_TIMER_STS)
      begin
         dma_suspend_flag <= wdata[irq_src_pkg::STS_HALT];
      end
   end

   // RQ7 all three timers share the one timer-group control entry
   // RQ18 RQ20 per-timer requests; a new request beats its acknowledge
   for (genvar t = 0; t < irq_src_pkg::NUM_TMR; t++)
   begin : g_tmr
      // an acknowledge clears one timer only; the group bit follows the or
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            per_timer_request_bits[t] <= 1'b0;
         end
         else if (timer_irq[t])
         begin
            per_timer_request_bits[t] <= 1'b1;
         end
         else if (timer_ack[t])
         begin
            per_timer_request_bits[t] <= 1'b0;
         end
      end
   end

   // RQ8 each dma channel has its own control entry and request bit
   // RQ20 RQ21 dma requests set by channel, cleared by acknowledge
   for (genvar d = 0; d < 2; d++)
   begin : g_dma
      // a new completion in the acknowledge cycle keeps the request set
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            dma_channel_requests[d] <= 1'b0;
         end
         else if (dma_done_irq[d])
         begin
            dma_channel_requests[d] <= 1'b1;
         end
         else if (dma_ack[d])
         begin
            dma_channel_requests[d] <= 1'b0;
         end
      end
   end

   // RQ9 RQ21 watchdog request from rising edge of timer 1 output
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wdog_prev <= 1'b0;
         watchdog_request <= 1'b0;
      end
      else
      begin
         // edge detect idles low, the quiet level of the timer output
         wdog_prev <= timer1_output;
         if (timer1_output && !wdog_prev)
         begin
            watchdog_request <= 1'b1;
         end
         else if (wdog_ack)
         begin
            watchdog_request <= 1'b0;
         end
      end
   end

   // RQ22 RQ23 serial request follows its flags, not the acknowledge
   always_ff @(posedge pclk or negedge presetn)
   begin
      // registered once so request view and eligibility see one value
      if (!presetn)
      begin
         serial_request <= 1'b0;
      end
      else
      begin
         serial_request <= serial_irq_enable & (|serial_flags);
      end
   end

   always_comb
   begin
      // reads zero after reset; software must not rely on that
      request_view = '0;
      // RQ19 timer group bit is the or
      request_view[irq_src_pkg::REQ_TMR] = |per_timer_request_bits;
      request_view[irq_src_pkg::REQ_DMA0] = dma_channel_requests[0];
      request_view[irq_src_pkg::REQ_DMA1] = dma_channel_requests[1];
      // RQ24 pins reflected, no latch
      request_view[irq_src_pkg::REQ_EXT_LSB +: irq_src_pkg::NUM_EXT] = ext_sync;
      request_view[irq_src_pkg::REQ_WDOG] = watchdog_request;
      // RQ13 serial at bit 10
      request_view[irq_src_pkg::REQ_SERIAL] = serial_request;
      status_view = '0;
      status_view[irq_src_pkg::STS_HALT] = dma_suspend_flag;
      status_view[irq_src_pkg::NUM_TMR-1:0] = per_timer_request_bits;
      pending = '0;
      pending[irq_src_pkg::SRC_TMR] = |per_timer_request_bits;
      pending[irq_src_pkg::SRC_DMA0] = dma_channel_requests[0];
      pending[irq_src_pkg::SRC_DMA1] = dma_channel_requests[1];
      pending[irq_src_pkg::SRC_WDOG] = watchdog_request;
      pending[irq_src_pkg::SRC_SERIAL] = serial_request;
   end

   // RQ26 read mux; request register is read only, reserved reads zero
   always_comb
   begin
      rdata_mux = '0;
      if (ctl_hit[irq_src_pkg::SRC_TMR])
      begin
         rdata_mux = {12'h000, source_mask_bit[0], source_priority_field[0]};
      end
      else if (ctl_hit[irq_src_pkg::SRC_DMA0])
      begin
         rdata_mux = {12'h000, source_mask_bit[1], source_priority_field[1]};
      end
      else if (ctl_hit[irq_src_pkg::SRC_DMA1])
      begin
         rdata_mux = {12'h000, source_mask_bit[2], source_priority_field[2]};
      end
      else if (ctl_hit[irq_src_pkg::SRC_WDOG])
      begin
         rdata_mux = {12'h000, source_mask_bit[3], source_priority_field[3]};
      end
      else if (ctl_hit[irq_src_pkg::SRC_SERIAL])
      begin
         // RQ14 bit 4 always reads one
         rdata_mux = {11'h000, 1'b1, source_mask_bit[4], source_priority_field[4]};
      end
      else if (word_idx == irq_src_pkg::IDX_REQUEST)
      begin
         rdata_mux = request_view;
      end
      else if (word_idx == irq_src_pkg::IDX_TIMER_STS)
      begin
         rdata_mux = status_view;
      end
      else if (word_idx == irq_src_pkg::IDX_GLOBAL_MASK)
      begin
         // global view: timer bit 0, dma bits 3..2, watchdog 9, serial 10
         rdata_mux[irq_src_pkg::REQ_TMR] = source_mask_bit[0];
         rdata_mux[irq_src_pkg::REQ_DMA0] = source_mask_bit[1];
         rdata_mux[irq_src_pkg::REQ_DMA1] = source_mask_bit[2];
         rdata_mux[irq_src_pkg::REQ_WDOG] = source_mask_bit[3];
         rdata_mux[irq_src_pkg::REQ_SERIAL] = source_mask_bit[4];
      end
      else if (word_idx == irq_src_pkg::IDX_PRIO_THRESH)
      begin
         rdata_mux = {13'h0000, priority_threshold};
      end
   end

   // apb answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         // pslverr only for unmapped words; nothing is written then
         pslverr <= psel & penable & ~pready & ~addr_ok;
         // prdata changes only on reads, so it stands until the next one
         if (rd_en)
            prdata <= {16'h0000, rdata_mux};
      end
   end

   // RQ5 RQ6 eligibility: lower code is higher priority, above threshold blocked
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         source_eligible <= '0;
         dma_suspend <= 1'b0;
         src_ctl <= '0;
      end
      else
      begin
         // eligibility lags the registers by one cycle
         for (int i = 0; i < irq_src_pkg::NUM_SRC; i++)
         begin
            source_eligible[i] <= pending[i] & ~source_mask_bit[i]
               & (source_priority_field[i] <= priority_threshold);
         end
         dma_suspend <= dma_suspend_flag;
         // a flop copy lets the arbiter read mask and priority without a long path
         src_ctl.source_mask_bit <= source_mask_bit;
         src_ctl.source_priority_field <= source_priority_field;
      end
   end
endmodule : internal_irq_source_control

// File: bench/irq_src_monitor.sv
// checker: bus timing and source-control relations seen at the block ports
`timescale 1ns/1ns
module irq_src_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_irq_enable,
   input wire irq_src_pkg::serial_flags_t serial_flags,
   input wire logic nmi_taken,
   input wire logic irq_return,
   input wire logic dma_suspend,
   input wire logic [irq_src_pkg::NUM_SRC-1:0] source_eligible,
   input wire irq_src_pkg::src_ctl_t src_ctl
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence access_start;
      psel && $rose(penable);
   endsequence
   // two registered stages lie between the serial cause and eligibility
   sequence serial_quiet;
      (!serial_irq_enable || serial_flags == '0) [*3];
   endsequence
   access_two_a: assert property (access_start |-> !pready ##1 pready)
      else $error("pready not on second access cycle");
   pready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
      else $error("pready outside access or longer than one cycle");
   slverr_pair_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   halt_sets_a: assert property (nmi_taken |-> ##2 dma_suspend)
      else $error("dma not suspended after nmi");
   halt_clears_a: assert property (irq_return && !nmi_taken |-> ##2 !dma_suspend)
      else $error("dma still suspended after interrupt return");
   ctl_reset_a: assert property ($rose(presetn) |=> src_ctl == '1)
      else $error("controls not masked at lowest priority after reset");
   masked_blocked_a: assert property ((source_eligible & src_ctl.source_mask_bit) == '0)
      else $error("masked source eligible");
   serial_quiet_a: assert property (serial_quiet |-> !source_eligible[irq_src_pkg::SRC_SERIAL])
      else $error("serial eligible without cause");
endmodule : irq_src_monitor
bind internal_irq_source_control irq_src_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_irq_enable(serial_irq_enable), .serial_flags(serial_flags), .nmi_taken(nmi_taken),
   .irq_return(irq_return), .dma_suspend(dma_suspend), .source_eligible(source_eligible),
   .src_ctl(src_ctl));

// File: bench/irq_periph_model.sv
// peripheral and core model: request, acknowledge and level sources
`timescale 1ns/1ns
module irq_periph_model (
   input wire logic pclk,
   output logic [2:0] timer_irq,
   output logic timer1_output,
   output logic [1:0] dma_done_irq,
   output logic [1:0] dma_ack,
   output logic wdog_ack,
   output logic [2:0] timer_ack,
   output logic serial_irq_enable,
   output irq_src_pkg::serial_flags_t serial_flags,
   output logic [4:0] external_pin_requests,
   output logic nmi_taken,
   output logic irq_return
);
   logic [13:0] ev = 14'h0000;
   assign {timer1_output, irq_return, nmi_taken, wdog_ack, dma_ack, timer_ack, dma_done_irq,
      timer_irq} = ev;
   initial
   begin
      serial_irq_enable = 1'b0;
      serial_flags = '0;
      external_pin_requests = 5'h00;
   end
   // one-cycle events; timer1 output rises and falls within the pulse
   task automatic pulse(input logic [13:0] which);
      @(posedge pclk);
      ev <= which;
      @(posedge pclk);
      ev <= 14'h0000;
   endtask : pulse
   task automatic levels(input logic en, input logic [5:0] f, input logic [4:0] pins);
      @(posedge pclk);
      serial_irq_enable <= en;
      serial_flags <= f;
      external_pin_requests <= pins;
   endtask : levels
endmodule : irq_periph_model

// File: bench/testbench.sv
// testbench: register, request and halt checks over apb
`timescale 1ns/1ns
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, errv, timer1_output, wdog_ack, serial_irq_enable;
   logic nmi_taken, irq_return, dma_suspend;
   logic [2:0] timer_irq, timer_ack;
   logic [1:0] dma_done_irq, dma_ack;
   logic [4:0] external_pin_requests, source_eligible;
   irq_src_pkg::serial_flags_t serial_flags;
   irq_src_pkg::src_ctl_t src_ctl;
   int miscompares = 0;
   int num_checks = 0;
   always #2 pclk = ~pclk;
   internal_irq_source_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq),
      .timer1_output(timer1_output), .dma_done_irq(dma_done_irq), .dma_ack(dma_ack),
      .wdog_ack(wdog_ack), .timer_ack(timer_ack), .serial_irq_enable(serial_irq_enable),
      .serial_flags(serial_flags), .external_pin_requests(external_pin_requests),
      .nmi_taken(nmi_taken), .irq_return(irq_return), .dma_suspend(dma_suspend),
      .source_eligible(source_eligible), .src_ctl(src_ctl));
   irq_periph_model p (.pclk(pclk), .timer_irq(timer_irq), .timer1_output(timer1_output),
      .dma_done_irq(dma_done_irq), .dma_ack(dma_ack), .wdog_ack(wdog_ack),
      .timer_ack(timer_ack), .serial_irq_enable(serial_irq_enable),
      .serial_flags(serial_flags), .external_pin_requests(external_pin_requests),
      .nmi_taken(nmi_taken), .irq_return(irq_return));
   task automatic summarize;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // registers sit at four times their index; the request is held until pready
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
      if (pready !== 1'b1)
      begin
         miscompares++;
         summarize();
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rc(input string what, input logic [7:0] idx, input logic [15:0] exp);
      apb(1'b0, idx, 16'h0000);
      chk(what, rdv, {16'h0000, exp});
   endtask : rc
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rc("timer ctl", irq_src_pkg::IDX_TIMER_CTL, 16'h000f);
      rc("dma0 ctl", irq_src_pkg::IDX_DMA0_CTL, 16'h000f);
      rc("dma1 ctl", irq_src_pkg::IDX_DMA1_CTL, 16'h000f);
      rc("wdog ctl", irq_src_pkg::IDX_WDOG_CTL, 16'h000f);
      rc("serial ctl", irq_src_pkg::IDX_SERIAL_CTL, 16'h001f);
      apb(1'b1, irq_src_pkg::IDX_DMA0_CTL, 16'h0002);
      rc("dma0 ctl", irq_src_pkg::IDX_DMA0_CTL, 16'h0002);
      apb(1'b0, irq_src_pkg::IDX_GLOBAL_MASK, 16'h0000);
      chk("mask view", rdv & 32'h060d, 32'h0609);
      apb(1'b1, irq_src_pkg::IDX_GLOBAL_MASK, 16'h0601);
      rc("dma1 ctl", irq_src_pkg::IDX_DMA1_CTL, 16'h0007);
      pstrb <= 4'hc;
      apb(1'b1, irq_src_pkg::IDX_DMA1_CTL, 16'h0000);
      pstrb <= 4'hf;
      rc("dma1 ctl", irq_src_pkg::IDX_DMA1_CTL, 16'h0007);
      // the model's timer output needs no set-up before the watchdog control write
      apb(1'b1, irq_src_pkg::IDX_SERIAL_CTL, 16'h0014);
      rc("serial ctl", irq_src_pkg::IDX_SERIAL_CTL, 16'h0014);
      apb(1'b1, irq_src_pkg::IDX_WDOG_CTL, 16'h0005);
      rc("wdog ctl", irq_src_pkg::IDX_WDOG_CTL, 16'h0005);
      apb(1'b0, 8'hff, 16'h0000);
      chk("unmapped", {errv, rdv[30:0]}, 32'h80000000);
      apb(1'b1, irq_src_pkg::IDX_REQUEST, 16'hffff);
      rc("request ro", irq_src_pkg::IDX_REQUEST, 16'h0000);
      // timer 2, both dma channels and a timer 1 output edge
      p.pulse(14'h201c);
      rc("request", irq_src_pkg::IDX_REQUEST, 16'h020d);
      rc("timer sts", irq_src_pkg::IDX_TIMER_STS, 16'h0004);
      p.pulse(14'h0500);
      rc("request", irq_src_pkg::IDX_REQUEST, 16'h0009);
      p.pulse(14'h0280);
      rc("request", irq_src_pkg::IDX_REQUEST, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         p.levels(1'b1, 6'h01 << i, 5'h00);
         repeat (3) @(posedge pclk);
         rc("serial req", irq_src_pkg::IDX_REQUEST, 16'h0400);
      end
      p.levels(1'b0, 6'h3f, 5'h16);
      repeat (4) @(posedge pclk);
      rc("pins", irq_src_pkg::IDX_REQUEST, 16'h0160);
      p.levels(1'b0, 6'h00, 5'h09);
      repeat (4) @(posedge pclk);
      rc("pins", irq_src_pkg::IDX_REQUEST, 16'h0090);
      p.levels(1'b0, 6'h00, 5'h00);
      p.pulse(14'h0800);
      repeat (2) @(posedge pclk);
      chk("suspend", {31'h0, dma_suspend}, 32'h1);
      rc("timer sts", irq_src_pkg::IDX_TIMER_STS, 16'h8000);
      p.pulse(14'h1000);
      repeat (2) @(posedge pclk);
      chk("suspend", {31'h0, dma_suspend}, 32'h0);
      apb(1'b1, irq_src_pkg::IDX_TIMER_STS, 16'h8000);
      repeat (2) @(posedge pclk);
      chk("suspend", {31'h0, dma_suspend}, 32'h1);
      apb(1'b1, irq_src_pkg::IDX_TIMER_STS, 16'h0000);
      p.pulse(14'h0001);
      apb(1'b1, irq_src_pkg::IDX_PRIO_THRESH, 16'h0002);
      apb(1'b1, irq_src_pkg::IDX_TIMER_CTL, 16'h0003);
      repeat (2) @(posedge pclk);
      chk("eligible", {27'h0, source_eligible}, 32'h0);
      chk("timer prio", {29'h0, src_ctl.source_priority_field[0]}, 32'h3);
      apb(1'b1, irq_src_pkg::IDX_PRIO_THRESH, 16'h0003);
      repeat (2) @(posedge pclk);
      chk("eligible", {27'h0, source_eligible}, 32'h1);
      p.pulse(14'h0002);
      rc("timer sts", irq_src_pkg::IDX_TIMER_STS, 16'h0003);
      p.pulse(14'h0060);
      rc("request", irq_src_pkg::IDX_REQUEST, 16'h0000);
      summarize();
   end
endmodule : testbench
